// File: tcbd_top.sv
// two-channel byte mover: request capture, priority, read/write pairs
// assumes a memory bus with combinational read data in the read cycle
// and software control bits given as plain level and pulse inputs
`timescale 1ns/10ps
`include "tcbd_defines.svh"
module tcbd_top (
    input wire logic clk, // system clock, 50 MHz
    input wire logic nrst, // async reset, low
    input wire logic channel_index, // register access channel
    input wire logic reg_wr, // byte write pulse
    input wire logic [2:0] reg_sel, // group and high byte
    input wire logic [7:0] reg_wdata, // write byte
    output logic [7:0] rd_data, // read byte, one cycle late
    input wire logic [1:0] en_set, // write 1 to channel_enable
    input wire logic [1:0] en_clr, // write 0 to channel_enable
    input wire logic [1:0] soft_trigger, // software request pulse
    input wire logic [1:0] latch_reload_cmd, // reload pulse
    input wire logic [1:0] burst_select, // 1 burst, 0 cycle steal
    input wire logic [5:0] hw_request_source, // 3 bits per channel
    input wire logic [3:0] src_dir, // 2 bits per channel
    input wire logic [3:0] dst_dir, // 2 bits per channel
    input wire logic reload_inhibit, // keep addresses at underflow
    input wire logic [1:0] stop_on_underflow, // auto disable
    input wire logic [1:0] latch_only_write, // writes reach latch only
    input wire logic [1:0] usb_host_path_enable, // paced usb path
    input wire logic [4:0] gen_req, // generic interrupt requests
    input wire logic rx_packet_ready, // out packet waiting
    input wire logic ep1_rx_not_empty, // endpoint 1 fifo has data
    input wire logic tx_packet_ready, // in packet armed
    input wire logic host_obuf_empty, // host output buffer empty
    input wire logic host_ibuf_full, // host input buffer has data
    input wire logic fifo_within_packet, // usb fifo has room
    input wire logic host_wr, // host writes input buffer
    input wire logic command_select_line, // host write is command
    input wire logic isr_active, // cpu runs an interrupt routine
    input wire logic [1:0] uf_clr, // clear underflow flag pulse
    input wire logic irq_clr, // clear interrupt request pulse
    output logic [15:0] mem_addr, // bus address
    output logic mem_rd, // bus read strobe
    output logic mem_wr, // bus write strobe
    output logic [7:0] mem_wdata, // bus write data
    input wire logic [7:0] mem_rdata, // bus read data
    output logic cpu_hold, // cpu kept off the bus
    output logic [1:0] channel_enable, // enable state
    output logic [1:0] suspended_flag, // paused by interrupt
    output logic [1:0] underflow_flag, // sticky underflow
    output logic dma_irq // sticky interrupt request
);
    tcbd_pkg::tcbd_state_t st_r, st_nxt;
    logic [1:0] en_r, pend_r, burst_r, ovr_r, susp_r, uf_r;
    logic irq_r, cur_r, rd_r, wr_r, hold_r;
    logic [15:0] addr_r;
    logic [7:0] data_r, rdd_r;
    logic [1:0] req_w, unf_w, gate_w, rdy_w, work_w, busy_w;
    logic [1:0] start_w, stop_w;
    logic [15:0] src_w [2];
    logic [15:0] dst_w [2];
    logic [15:0] cnt_w [2];
    tcbd_chan_if cif [2] ();

    // arbitration: channel 0 always first, re-decided after every pair
    wire idle = st_r == tcbd_pkg::ST_IDLE;
    wire go = idle && |rdy_w;
    wire sel = ~rdy_w[0];
    wire [15:0] src_sel = sel ? src_w[1] : src_w[0];
    wire [15:0] dst_cur = cur_r ? dst_w[1] : dst_w[0];
    wire cmd_wr = host_wr & command_select_line;

    // register read path: channel index picks the channel
    wire [15:0] rd_word = (reg_sel[2:1] == `TCBD_GRP_SRC) ?
        src_w[channel_index] : (reg_sel[2:1] == `TCBD_GRP_DST) ?
        dst_w[channel_index] : cnt_w[channel_index];
    wire [7:0] rd_byte = reg_sel[0] ? rd_word[15:8] : rd_word[7:0];

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ch
            // per-channel register file and request qualifier
            tcbd_chan u_chan (
                .clk(clk),
                .nrst(nrst),
                .bus(cif[i])
            );
            tcbd_req u_req (
                .clk(clk),
                .nrst(nrst),
                .factor(hw_request_source[3*i +: 3]),
                .gen_req(gen_req),
                .rx_packet_ready(rx_packet_ready),
                .ep1_rx_not_empty(ep1_rx_not_empty),
                .tx_packet_ready(tx_packet_ready),
                .obuf_empty(host_obuf_empty),
                .ibuf_full(host_ibuf_full),
                .fifo_room(fifo_within_packet),
                .paced_en(usb_host_path_enable[i] & ~burst_select[i]),
                .busy(busy_w[i]),
                .req(req_w[i])
            );
            // steering of the channel registers
            assign cif[i].wr_en = reg_wr && channel_index == 1'(i);
            assign cif[i].wr_sel = reg_sel;
            assign cif[i].wr_data = reg_wdata;
            assign cif[i].latch_only = latch_only_write[i];
            assign cif[i].src_dir = src_dir[2*i +: 2];
            assign cif[i].dst_dir = dst_dir[2*i +: 2];
            assign cif[i].reload_inhibit = reload_inhibit;
            assign cif[i].reload_cmd = latch_reload_cmd[i];
            assign cif[i].step = st_r == tcbd_pkg::ST_WR &&
                cur_r == 1'(i);
            assign unf_w[i] = cif[i].unf;
            assign src_w[i] = cif[i].src;
            assign dst_w[i] = cif[i].dst;
            assign cnt_w[i] = cif[i].cnt;
            // work, pause and readiness of the channel
            assign work_w[i] = pend_r[i] | burst_r[i];
            assign busy_w[i] = work_w[i] | (~idle & cur_r == 1'(i));
            assign gate_w[i] = isr_active & ~ovr_r[i];
            assign rdy_w[i] = en_r[i] & work_w[i] & ~gate_w[i];
            assign start_w[i] = go && sel == 1'(i);
            // host command ends a host-to-usb paced transfer
            assign stop_w[i] = cmd_wr & usb_host_path_enable[i] &
                hw_request_source[3*i +: 3] == `TCBD_FAC_TX_PKT;
            // enable: software set, underflow or command clears it
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    en_r[i] <= 1'b0;
                end else if (en_set[i]) begin
                    en_r[i] <= 1'b1;
                end else if (en_clr[i] | stop_w[i] |
                    (unf_w[i] & stop_on_underflow[i])) begin
                    en_r[i] <= 1'b0;
                end
            end
            // pending request; a new one wins over its own acceptance
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    pend_r[i] <= 1'b0;
                end else if (en_r[i] & (req_w[i] | soft_trigger[i])) begin
                    pend_r[i] <= 1'b1;
                end else if (start_w[i] | ~en_r[i] | stop_w[i]) begin
                    pend_r[i] <= 1'b0;
                end
            end
            // burst runs until the counter underflows
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    burst_r[i] <= 1'b0;
                end else if (unf_w[i] | ~en_r[i] | stop_w[i]) begin
                    burst_r[i] <= 1'b0;
                end else if (start_w[i] & burst_select[i]) begin
                    burst_r[i] <= 1'b1;
                end
            end
            // override lives until the routine ends
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ovr_r[i] <= 1'b0;
                end else begin
                    ovr_r[i] <= isr_active & (ovr_r[i] | en_set[i]);
                end
            end
            // suspend flag shows work held back by a routine
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    susp_r[i] <= 1'b0;
                end else begin
                    susp_r[i] <= gate_w[i] & work_w[i] & en_r[i];
                end
            end
            // sticky underflow flag, set beats clear
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    uf_r[i] <= 1'b0;
                end else if (unf_w[i]) begin
                    uf_r[i] <= 1'b1;
                end else if (uf_clr[i]) begin
                    uf_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // pair sequencer: one read, one write, then a free cycle for cpu
    always_comb begin
        unique case (st_r)
            tcbd_pkg::ST_IDLE: st_nxt = go ? tcbd_pkg::ST_RD :
                tcbd_pkg::ST_IDLE;
            tcbd_pkg::ST_RD: st_nxt = tcbd_pkg::ST_WR;
            tcbd_pkg::ST_WR: st_nxt = tcbd_pkg::ST_IDLE;
            default: st_nxt = tcbd_pkg::ST_IDLE;
        endcase
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= tcbd_pkg::ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // bus strobes are registered so outputs come from flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {cur_r, rd_r, wr_r, hold_r} <= 4'h0;
            addr_r <= `TCBD_WORD_RST;
            data_r <= `TCBD_BYTE_RST;
        end else if (go) begin
            {cur_r, rd_r, hold_r} <= {sel, 1'b1, 1'b1};
            addr_r <= src_sel;
        end else if (st_r == tcbd_pkg::ST_RD) begin
            {rd_r, wr_r} <= 2'h1;
            data_r <= mem_rdata;
            addr_r <= dst_cur;
        end else if (st_r == tcbd_pkg::ST_WR) begin
            {wr_r, hold_r} <= 2'h0;
        end
    end

    // interrupt request and read data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_r <= 1'b0;
            rdd_r <= `TCBD_BYTE_RST;
        end else begin
            irq_r <= (|unf_w) | (irq_r & ~irq_clr);
            rdd_r <= rd_byte;
        end
    end

    assign rd_data = rdd_r;
    assign mem_addr = addr_r;
    assign mem_rd = rd_r;
    assign mem_wr = wr_r;
    assign mem_wdata = data_r;
    assign cpu_hold = hold_r;
    assign channel_enable = en_r;
    assign suspended_flag = susp_r;
    assign underflow_flag = uf_r;
    assign dma_irq = irq_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_read;
        rd_r && !wr_r && hold_r;
    endsequence
    sequence s_write;
        wr_r && !rd_r && hold_r && mem_addr == $past(dst_cur);
    endsequence
    property p_pair;
        go |=> s_read ##1 s_write ##1 !hold_r;
    endproperty
    a_pair: assert property (p_pair)
        else $error("byte pair not read then write under hold");
    property p_prio;
        go && rdy_w[0] |=> cur_r == 1'b0;
    endproperty
    a_prio: assert property (p_prio)
        else $error("channel 1 served while channel 0 ready");
    property p_preempt;
        st_r == tcbd_pkg::ST_WR && cur_r && burst_r[1] && !unf_w[1]
            && rdy_w[0] ##1 rdy_w[0] |=> rd_r && !cur_r;
    endproperty
    a_preempt: assert property (p_preempt)
        else $error("channel 0 did not preempt burst");
    property p_one_byte;
        start_w[0] && !burst_select[0] && !req_w[0] && !soft_trigger[0]
            |=> !pend_r[0] && !burst_r[0];
    endproperty
    a_one_byte: assert property (p_one_byte)
        else $error("cycle steal left work after one byte");
    property p_burst;
        start_w[1] && burst_select[1] && !unf_w[1] |=> burst_r[1];
    endproperty
    a_burst: assert property (p_burst)
        else $error("burst did not stay active");
    property p_uf;
        unf_w[0] |=> underflow_flag[0] && dma_irq;
    endproperty
    a_uf: assert property (p_uf)
        else $error("underflow flag or request not set");
    property p_stop;
        unf_w[1] && stop_on_underflow[1] && !en_set[1] |=>
            !channel_enable[1];
    endproperty
    a_stop: assert property (p_stop)
        else $error("channel stayed enabled after underflow");
    property p_disabled;
        !en_r[0] && !en_set[0] |=> !(rd_r && !cur_r && $rose(rd_r));
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled channel started a transfer");
    property p_suspend;
        isr_active && !ovr_r[0] && pend_r[0] && en_r[0] |->
            !start_w[0] ##1 suspended_flag[0];
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("transfer not suspended in routine");
    property p_resume;
        isr_active && en_set[1] ##1 isr_active |=> !suspended_flag[1];
    endproperty
    a_resume: assert property (p_resume)
        else $error("enable write did not resume channel");
    property p_cmd_stop;
        stop_w[0] && !en_set[0] |=> !channel_enable[0] && !pend_r[0];
    endproperty
    a_cmd_stop: assert property (p_cmd_stop)
        else $error("host command did not stop transfer");
endmodule : tcbd_top

// File: tcbd_defines.svh
// constants of the two-channel byte mover: selects, codes, resets
// assumes inclusion by bare name from every file that needs them
`ifndef TCBD_DEFINES_SVH
`define TCBD_DEFINES_SVH
// register group in reg_sel[2:1], high byte flag in reg_sel[0]
`define TCBD_GRP_SRC 2'h0
`define TCBD_GRP_DST 2'h1
`define TCBD_GRP_CNT 2'h2
// address step codes
`define TCBD_DIR_INC 2'h1
`define TCBD_DIR_DEC 2'h2
// request factor codes above the five generic ones
`define TCBD_FAC_RX_PKT 3'h5
`define TCBD_FAC_EP1_NE 3'h6
`define TCBD_FAC_TX_PKT 3'h7
// reset values
`define TCBD_WORD_RST 16'h0000
`define TCBD_BYTE_RST 8'h00
`endif

// File: tcbd_pkg.sv
// types shared by the byte mover modules
// assumes nothing beyond a SystemVerilog compiler
package tcbd_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RD = 3'h2,
        ST_WR = 3'h4
    } tcbd_state_t;
endpackage : tcbd_pkg

// File: tcbd_chan_if.sv
// links the sequencer to one channel's address and count registers
// assumes one instance per channel, all on one clock
`timescale 1ns/10ps
interface tcbd_chan_if;
    logic wr_en;
    logic [2:0] wr_sel;
    logic [7:0] wr_data;
    logic latch_only;
    logic [1:0] src_dir;
    logic [1:0] dst_dir;
    logic reload_inhibit;
    logic reload_cmd;
    logic step;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] cnt;
    logic unf;
    modport ctl (output wr_en, wr_sel, wr_data, latch_only, src_dir,
        dst_dir, reload_inhibit, reload_cmd, step,
        input src, dst, cnt, unf);
    modport chan (input wr_en, wr_sel, wr_data, latch_only, src_dir,
        dst_dir, reload_inhibit, reload_cmd, step,
        output src, dst, cnt, unf);
endinterface : tcbd_chan_if

// File: tcbd_req.sv
// request qualifier of one channel: factor select and pacing
// assumes all inputs synchronous to clk
`timescale 1ns/10ps
`include "tcbd_defines.svh"
module tcbd_req (
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, low
    input wire logic [2:0] factor, // hw_request_source
    input wire logic [4:0] gen_req, // generic interrupt requests
    input wire logic rx_packet_ready, // out packet waiting
    input wire logic ep1_rx_not_empty, // endpoint 1 fifo has data
    input wire logic tx_packet_ready, // in packet armed
    input wire logic obuf_empty, // host output buffer empty
    input wire logic ibuf_full, // host input buffer holds data
    input wire logic fifo_room, // usb fifo within packet size
    input wire logic paced_en, // usb host path active in cycle steal mode, either direction
    input wire logic busy, // channel already has work
    output logic req // one request
);
    logic lvl_r;
    wire [7:0] raw = {~tx_packet_ready, ep1_rx_not_empty,
        rx_packet_ready, gen_req};
    wire lvl = raw[factor];
    wire usb_fac = factor >= `TCBD_FAC_RX_PKT;
    wire pace_ok = (factor == `TCBD_FAC_TX_PKT) ?
        (ibuf_full & fifo_room) : obuf_empty;
    // paced factors are levels re-armed per byte; others fire on edges
    assign req = (paced_en & usb_fac) ? (lvl & pace_ok & ~busy) :
        (lvl & ~lvl_r);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lvl_r <= 1'b0;
        end else begin
            lvl_r <= lvl;
        end
    end
endmodule : tcbd_req

// File: tcbd_chan.sv
// working registers and shadow latches of one channel
// assumes the sequencer steps it only while the channel is enabled
`timescale 1ns/10ps
`include "tcbd_defines.svh"
module tcbd_chan (
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, low
    tcbd_chan_if.chan bus // sequencer side
);
    logic [15:0] src_r, dst_r, cnt_r, src_l_r, dst_l_r, cnt_l_r;
    function automatic logic [15:0] mv(logic [15:0] a, logic [1:0] d);
        mv = (d == `TCBD_DIR_INC) ? a + 16'h0001 :
            (d == `TCBD_DIR_DEC) ? a - 16'h0001 : a;
    endfunction : mv
    function automatic logic [15:0] mg(logic [15:0] o, logic h,
        logic [7:0] b);
        mg = h ? {b, o[7:0]} : {o[15:8], b};
    endfunction : mg
    // byte writes decode
    wire hi = bus.wr_sel[0];
    wire w_s = bus.wr_en && bus.wr_sel[2:1] == `TCBD_GRP_SRC;
    wire w_d = bus.wr_en && bus.wr_sel[2:1] == `TCBD_GRP_DST;
    wire w_c = bus.wr_en && bus.wr_sel[2:1] == `TCBD_GRP_CNT;
    wire w_work = ~bus.latch_only;
    wire under = bus.step && cnt_r == 16'h0000;
    wire rl_ad = bus.reload_cmd | (under & ~bus.reload_inhibit);
    wire rl_cnt = bus.reload_cmd | under;
    // reload beats a step, a step beats a software write
    wire [15:0] src_nxt = rl_ad ? src_l_r : bus.step ?
        mv(src_r, bus.src_dir) : (w_s & w_work) ? mg(src_r, hi,
        bus.wr_data) : src_r;
    wire [15:0] dst_nxt = rl_ad ? dst_l_r : bus.step ?
        mv(dst_r, bus.dst_dir) : (w_d & w_work) ? mg(dst_r, hi,
        bus.wr_data) : dst_r;
    wire [15:0] cnt_nxt = rl_cnt ? cnt_l_r : bus.step ?
        cnt_r - 16'h0001 : (w_c & w_work) ? mg(cnt_r, hi,
        bus.wr_data) : cnt_r;
    assign bus.src = src_r;
    assign bus.dst = dst_r;
    assign bus.cnt = cnt_r;
    assign bus.unf = under;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {src_r, dst_r, cnt_r} <= {3{`TCBD_WORD_RST}};
            {src_l_r, dst_l_r, cnt_l_r} <= {3{`TCBD_WORD_RST}};
        end else begin
            src_r <= src_nxt;
            dst_r <= dst_nxt;
            cnt_r <= cnt_nxt;
            if (w_s) src_l_r <= mg(src_l_r, hi, bus.wr_data);
            if (w_d) dst_l_r <= mg(dst_l_r, hi, bus.wr_data);
            if (w_c) cnt_l_r <= mg(cnt_l_r, hi, bus.wr_data);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_unf_reload;
        under && !bus.reload_cmd && !bus.reload_inhibit |=>
            cnt_r == $past(cnt_l_r) && dst_r == $past(dst_l_r);
    endproperty
    a_unf_reload: assert property (p_unf_reload)
        else $error("underflow did not reload from latches");
    property p_cmd_reload;
        bus.reload_cmd |=> src_r == $past(src_l_r) &&
            cnt_r == $past(cnt_l_r);
    endproperty
    a_cmd_reload: assert property (p_cmd_reload)
        else $error("reload command did not copy latches");
endmodule : tcbd_chan

// File: tcbd_mem_model.sv
// byte memory on the mover's bus, read data combinational
// assumes registered strobes from the mover on the same clock
`timescale 1ns/10ps
module tcbd_mem_model (
    input wire logic clk, // system clock
    input wire logic [15:0] mem_addr, // bus address
    input wire logic mem_rd, // read strobe
    input wire logic mem_wr, // write strobe
    input wire logic [7:0] mem_wdata, // write data
    output logic [7:0] mem_rdata // read data
);
    logic [7:0] mem [256];
    logic [7:0] last_r;
    // a released bus shows the inverse, so stale data never passes
    assign mem_rdata = mem_rd ? mem[mem_addr[7:0]] : ~last_r;
    // store writes and remember the last byte driven
    always @(posedge clk) begin
        if (mem_wr)
            mem[mem_addr[7:0]] <= mem_wdata;
        if (mem_rd)
            last_r <= mem[mem_addr[7:0]];
    end
endmodule : tcbd_mem_model

// File: tcbd_top_tb.sv
// bench: byte mover against an integer model and a memory model
// assumes tcbd_top and tcbd_mem_model are compiled first
`timescale 1ns/10ps
module tcbd_top_tb;
    logic clk, nrst, channel_index, reg_wr, reload_inhibit, irq_clr;
    logic rx_packet_ready, ep1_rx_not_empty, tx_packet_ready, host_wr;
    logic host_obuf_empty, host_ibuf_full, fifo_within_packet, isr_active;
    logic command_select_line, mem_rd, mem_wr, cpu_hold, dma_irq;
    logic [1:0] en_set, en_clr, soft_trigger, latch_reload_cmd, uf_clr;
    logic [1:0] burst_select, stop_on_underflow, latch_only_write;
    logic [1:0] usb_host_path_enable, channel_enable, suspended_flag;
    logic [1:0] underflow_flag;
    logic [2:0] reg_sel;
    logic [3:0] src_dir, dst_dir;
    logic [4:0] gen_req;
    logic [5:0] hw_request_source;
    logic [7:0] reg_wdata, rd_data, mem_wdata, mem_rdata, lfsr;
    logic [7:0] exp_mem [256];
    logic [15:0] mem_addr;
    int failures, n_compared, cyc, n_wr, cur;
    int ms[2], md[2], mc[2], ls[2], ld[2], lc[2];
    int ds[2] = '{1, -1};
    int dd[2] = '{-1, 1};

    tcbd_top u_dut (.*);
    tcbd_mem_model u_mem (.*);

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next

    task automatic chk(input bit ok, input string msg);
        n_compared++;
        if (!ok) begin
            failures++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic stop_test;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    // hang guard, far above the hundred or so cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            stop_test();
        end
    end

    // bus monitor: each pair checked and stepped in the model
    always @(posedge clk) begin
        if (mem_rd === 1'b1)
            chk(mem_addr === 16'(ms[cur]) && cpu_hold === 1'b1, "rd");
        if (mem_wr === 1'b1) begin
            chk(mem_addr === 16'(md[cur]), "dst");
            chk(mem_wdata === exp_mem[ms[cur] & 255], "data");
            exp_mem[md[cur] & 255] = exp_mem[ms[cur] & 255];
            n_wr++;
            ms[cur] += ds[cur];
            md[cur] += dd[cur];
            if (mc[cur] == 0) begin
                {ms[cur], md[cur], mc[cur]} = {ls[cur], ld[cur], lc[cur]};
            end else
                mc[cur]--;
        end
    end

    // register bytes go low first, reg_wr held high one cycle per byte
    task automatic wr16(input int ch, input logic [1:0] g, input int v);
        for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            channel_index <= ch[0];
            reg_sel <= {g, b[0]};
            reg_wdata <= v[8*b +: 8];
            reg_wr <= 1'b1;
        end
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr16

    task automatic cfg(input int ch, input int s, input int d, input int c);
        wr16(ch, 2'h0, s);
        wr16(ch, 2'h1, d);
        wr16(ch, 2'h2, c);
        {ms[ch], md[ch], mc[ch], ls[ch], ld[ch], lc[ch]} = {s, d, c, s, d, c};
    endtask : cfg

    // high byte read first; read data lags the select by one cycle
    task automatic rd16(input int ch, input logic [1:0] g, input int v);
        for (int b = 1; b >= 0; b--) begin
            @(posedge clk);
            channel_index <= ch[0];
            reg_sel <= {g, b[0]};
            repeat (2) @(posedge clk);
            #1 chk(rd_data === v[8*b +: 8], "readback");
        end
    endtask : rd16

    task automatic trig(input logic [1:0] m);
        @(posedge clk);
        soft_trigger <= m;
        @(posedge clk);
        soft_trigger <= 2'h0;
    endtask : trig

    // bounded wait for the expected number of written bytes
    task automatic wait_wr(input int n);
        for (int i = 0; i < 80 && n_wr < n; i++)
            @(posedge clk);
        repeat (4) @(posedge clk);
        #1 chk(n_wr == n, "byte count");
    endtask : wait_wr

    initial begin
        {nrst, channel_index, reg_wr, reload_inhibit, irq_clr, host_wr,
            rx_packet_ready, ep1_rx_not_empty, tx_packet_ready, isr_active,
            host_obuf_empty, host_ibuf_full, fifo_within_packet, en_set,
            command_select_line, en_clr, soft_trigger, latch_reload_cmd,
            uf_clr, burst_select, stop_on_underflow, latch_only_write,
            usb_host_path_enable, reg_sel, gen_req, reg_wdata} = '0;
        {src_dir, dst_dir, hw_request_source} = {4'h9, 4'h6, 6'h03};
        lfsr = 8'h62;
        for (int i = 0; i < 256; i++) begin
            lfsr = lfsr_next(lfsr);
            u_mem.mem[i] = lfsr;
            exp_mem[i] = lfsr;
        end
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        burst_select <= 2'h2;
        stop_on_underflow <= 2'h2;
        cfg(0, 'h10, 'h40, 1);
        cfg(1, 'h80, 'h90, 2);
        rd16(0, 2'h0, 'h10);
        trig(2'h1);
        wait_wr(0);
        @(posedge clk);
        en_set <= 2'h3;
        @(posedge clk);
        en_set <= 2'h0;
        isr_active <= 1'b1;
        gen_req <= 5'h08;
        repeat (8) @(posedge clk);
        #1 chk(n_wr == 0 && suspended_flag[0] === 1'b1, "suspend");
        @(posedge clk);
        isr_active <= 1'b0;
        wait_wr(1);
        chk(suspended_flag === 2'h0 && dma_irq === 1'b0, "resume");
        trig(2'h1);
        wait_wr(2);
        chk(underflow_flag === 2'h1 && dma_irq === 1'b1, "uf0");
        chk(channel_enable === 2'h3, "keep enable");
        cur = 1;
        trig(2'h2);
        wait_wr(5);
        chk(channel_enable === 2'h1 && underflow_flag === 2'h3, "uf1");
        rd16(1, 2'h0, 'h80);
        rd16(1, 2'h2, 2);
        @(posedge clk);
        latch_only_write <= 2'h2;
        wr16(1, 2'h0, 'h55);
        rd16(1, 2'h0, 'h80);
        @(posedge clk);
        {latch_reload_cmd, uf_clr, irq_clr} <= {2'h2, 2'h3, 1'b1};
        @(posedge clk);
        {latch_reload_cmd, uf_clr, irq_clr} <= '0;
        rd16(1, 2'h0, 'h55);
        chk(underflow_flag === 2'h0 && dma_irq === 1'b0, "clear");
        stop_test();
    end
endmodule : tcbd_top_tb
